// *** design/flash_protect_pkg.sv ***
package flash_protect_pkg;
  localparam int CLK_MHZ         = 250;
  localparam int UNLOCK_DELAY_US = 100;
  localparam int UNLOCK_TOL_US   = 20;
  localparam int PAGE_PROG_US    = 300;
  localparam int SECTOR_ERASE_US = 1000;
  localparam int UNLOCK_DELAY_CYC = UNLOCK_DELAY_US * CLK_MHZ;
  localparam int PAGE_PROG_CYC    = PAGE_PROG_US * CLK_MHZ;
  localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_US * CLK_MHZ;
  localparam int NUM_SECTORS_DEF  = 256;
  localparam int TIMER_W_DEF      = 24;

  localparam logic [1:0] MODE_NONE     = 2'h3;
  localparam logic [1:0] MODE_PERSIST  = 2'h2;
  localparam logic [1:0] MODE_PASSWORD = 2'h1;
  localparam logic [1:0] MODE_ILLEGAL  = 2'h0;

  localparam logic [7:0]  DYB_CLEAR_BYTE = 8'h00;
  localparam logic [7:0]  DYB_SET_BYTE   = 8'hFF;
  localparam logic [63:0] PASSWORD_RESET = 64'hFFFFFFFFFFFFFFFF;

  // status byte in data[7:0], config byte in data[15:8]
  localparam int STATUS_WRITE_DISABLE_FLAG_POS    = 7;
  localparam int RANGE_LSB   = 2;
  localparam int CFG_LSB     = 8;
  localparam int DIR_POS     = 5;
  localparam int CFG_OTP_LSB = 2;
  localparam int FREEZE_POS  = 0;

  localparam logic [2:0] RANGE_NONE = 3'h0;
  localparam logic [2:0] RANGE_ALL  = 3'h7;

  typedef enum logic [3:0] {
    CMD_WRITE_STATUS,
    CMD_CLEAR_STATUS,
    CMD_ARRAY_MODIFY,
    CMD_OTP_AREA_PROG,
    CMD_OTP_CFG_PROG,
    CMD_MODE_PROG,
    CMD_PASSWORD_PROG,
    CMD_PASSWORD_UNLOCK,
    CMD_GUARD_CLEAR,
    CMD_PPB_PROG,
    CMD_PPB_ERASE,
    CMD_PPB_READ,
    CMD_DYB_WRITE,
    CMD_DYB_READ
  } cmd_t;
endpackage

// *** design/flash_sector_write_protection.sv ***
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - direction 0: codes 0..7 protect none, upper 64th up to half, then all.
// - direction 1: same fractions counted from the lowest sector.
// - range size from three range bits, start side from config bit five.
// - sector protected if range or per-sector scheme protects it.
// - freeze bit blocks range controls and one-time area until power cycle.
// - write-protect low with disable flag set blocks status and config writes.
// - each sector has persistent and dynamic lock; either zero refuses modify.
// - guard bit zero refuses program or erase of persistent locks.
// - persistent mode: guard set at reset, clearable, never set by command.
// - password mode: guard cleared at reset and by a command anytime.
// - password mode: guard set only when supplied value matches 64-bit password.
// - mode bits 11 default persistent, 10 persistent, 01 password.
// - programming mode bits to 00 fails as a programming error.
// - once mode chosen, otp config, mode, password changes fail with error.
// - mode register programming takes page time with busy flag shown.
// - fresh device starts persistent mode with all sectors unprotected.
// - persistent locks programmed to 0 singly, erased to 1 together.
// - guard zero at persistent-lock program or erase: not executed, error.
// - lock program takes page time, erase takes sector time, busy readable.
// - a read returns the persistent lock of the addressed sector.
// - dynamic write clears or sets sector volatile bit any number of times.
// - access byte 00 clears, FF sets; dynamic bits reset to ones.
// - wrong password sets error, keeps busy, leaves guard zero.
// - unlock attempts spaced by 100 us; correct password skips the delay.
// - software reset leaves guard; only power or hardware reset reinitialise.
module flash_sector_write_protection
  import flash_protect_pkg::*;
#(
  parameter int NUM_SECTORS  = NUM_SECTORS_DEF,
  parameter int SECT_W       = $clog2(NUM_SECTORS),
  parameter int TIMER_W      = TIMER_W_DEF,
  parameter int UNLOCK_CYC   = UNLOCK_DELAY_CYC,
  parameter int PROG_CYC     = PAGE_PROG_CYC,
  parameter int ERASE_CYC    = SECTOR_ERASE_CYC
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_arst_n,
  input  wire logic              i_hw_reset_n,
  input  wire logic              i_wp_n,
  input  wire logic              i_cs_n,
  input  wire logic              i_cmd_valid,
  input  wire cmd_t              i_cmd_op,
  input  wire logic [SECT_W-1:0] i_cmd_sector,
  input  wire logic [63:0]       i_cmd_data,
  output logic                   o_busy,
  output logic                   o_prog_error,
  output logic                   o_guard,
  output logic [1:0]             o_mode,
  output logic [2:0]             o_range_code,
  output logic                   o_range_direction_select,
  output logic                   o_status_write_disable_flag,
  output logic                   o_freeze,
  output logic                   o_grant,
  output logic                   o_rd_valid,
  output logic [7:0]             o_rd_data
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] hw_sync_q;
  logic [1:0] wp_sync_q;
  logic [1:0] cs_sync_q;
  logic       cs_last_q;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hw_sync_q <= 2'h0;
      wp_sync_q <= 2'h3;
      cs_sync_q <= 2'h3;
      cs_last_q <= 1'b1;
    end else begin
      hw_sync_q <= {hw_sync_q[0], i_hw_reset_n};
      wp_sync_q <= {wp_sync_q[0], i_wp_n};
      cs_sync_q <= {cs_sync_q[0], i_cs_n};
      cs_last_q <= cs_sync_q[1];
    end
  end

  logic hw_rst;
  logic wp_low;
  logic take;
  // a command is taken when its frame closes; decoder holds fields stable by then
  assign hw_rst = !hw_sync_q[1];
  assign wp_low = !wp_sync_q[1];
  assign take   = cs_sync_q[1] && !cs_last_q && i_cmd_valid;

  ////////////////////////////////////////////////////////////////////////////
  // protection state
  logic [NUM_SECTORS-1:0] ppb_q, ppb_d;
  logic [NUM_SECTORS-1:0] dyb_q, dyb_d;
  logic [63:0]            pass_q, pass_d;
  logic [1:0]             mode_q, mode_d;
  logic [2:0]             range_q, range_d;
  logic [3:0]             cfg_q, cfg_d;
  logic                   status_write_disable_flag_q, status_write_disable_flag_d;
  logic                   freeze_q, freeze_d;
  logic                   guard_q, guard_d;
  logic                   err_q, err_d;
  logic [TIMER_W-1:0]     cnt_q, cnt_d;
  logic                   busy_q, busy_d;
  logic                   grant_q, grant_d;
  logic                   rdv_q, rdv_d;
  logic [7:0]             rdd_q, rdd_d;

  logic [NUM_SECTORS-1:0] range_hit;
  logic                   dir_bit;
  logic                   pw_mode;
  logic                   mode_chosen;
  logic                   sect_prot;

  assign dir_bit     = cfg_q[DIR_POS-CFG_OTP_LSB];
  assign pw_mode     = (mode_q == MODE_PASSWORD);
  assign mode_chosen = (mode_q != MODE_NONE);

  // span of the range is NUM_SECTORS / 2^(7-code) for codes 1..6
  genvar gs;
  generate
    for (gs = 0; gs < NUM_SECTORS; gs++) begin : g_range
      always_comb begin
        int span;
        span = NUM_SECTORS >> (int'(RANGE_ALL) - int'(range_q));
        if (range_q == RANGE_NONE) begin
          range_hit[gs] = 1'b0;
        end else if (range_q == RANGE_ALL) begin
          range_hit[gs] = 1'b1;
        end else if (dir_bit) begin
          range_hit[gs] = (gs < span);
        end else begin
          range_hit[gs] = (gs >= NUM_SECTORS - span);
        end
      end
    end
  endgenerate

  // either scheme alone is enough to block the target
  assign sect_prot = range_hit[i_cmd_sector] || !ppb_q[i_cmd_sector]
                     || !dyb_q[i_cmd_sector];

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    ppb_d    = ppb_q;
    dyb_d    = dyb_q;
    pass_d   = pass_q;
    mode_d   = mode_q;
    range_d  = range_q;
    cfg_d    = cfg_q;
    status_write_disable_flag_d   = status_write_disable_flag_q;
    freeze_d = freeze_q;
    guard_d  = guard_q;
    err_d    = err_q;
    cnt_d    = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
    grant_d  = 1'b0;
    rdv_d    = 1'b0;
    rdd_d    = rdd_q;
    // software reset has no path into the guard; only these two resets do
    if (hw_rst) begin
      guard_d = !pw_mode;
      dyb_d   = '1;
      err_d   = 1'b0;
      cnt_d   = '0;
    end else if (take && !busy_q) begin
      case (i_cmd_op)
        CMD_WRITE_STATUS: begin
          if (!(wp_low && status_write_disable_flag_q)) begin
            if (!freeze_q) begin
              range_d = i_cmd_data[RANGE_LSB +: 3];
              status_write_disable_flag_d  = i_cmd_data[STATUS_WRITE_DISABLE_FLAG_POS];
            end
            if (cfg_q != i_cmd_data[CFG_LSB+CFG_OTP_LSB +: 4]) begin
              if (mode_chosen || freeze_q) begin
                err_d = 1'b1;
              end else begin
                cfg_d = i_cmd_data[CFG_LSB+CFG_OTP_LSB +: 4];
              end
            end
            // freeze is sticky until power goes away
            freeze_d = freeze_q || i_cmd_data[CFG_LSB+FREEZE_POS];
          end
        end
        CMD_CLEAR_STATUS: begin
          err_d = 1'b0;
        end
        CMD_ARRAY_MODIFY: begin
          if (sect_prot) begin
            err_d = 1'b1;
          end else begin
            grant_d = 1'b1;
          end
        end
        CMD_OTP_AREA_PROG: begin
          if (freeze_q) begin
            err_d = 1'b1;
          end else begin
            grant_d = 1'b1;
          end
        end
        CMD_OTP_CFG_PROG: begin
          if (mode_chosen) begin
            err_d = 1'b1;
          end else begin
            grant_d = 1'b1;
          end
        end
        CMD_MODE_PROG: begin
          if (mode_chosen || i_cmd_data[1:0] == MODE_ILLEGAL) begin
            err_d = 1'b1;
          end else begin
            mode_d = i_cmd_data[1:0];
            cnt_d  = TIMER_W'(PROG_CYC);
          end
        end
        CMD_PASSWORD_PROG: begin
          if (mode_chosen) begin
            err_d = 1'b1;
          end else begin
            // cells only move from 1 to 0
            pass_d = pass_q & i_cmd_data;
            cnt_d  = TIMER_W'(PROG_CYC);
          end
        end
        CMD_PASSWORD_UNLOCK: begin
          if (pw_mode) begin
            if (i_cmd_data == pass_q) begin
              guard_d = 1'b1;
            end else begin
              err_d = 1'b1;
              cnt_d = TIMER_W'(UNLOCK_CYC);
            end
          end
        end
        CMD_GUARD_CLEAR: begin
          guard_d = 1'b0;
        end
        CMD_PPB_PROG: begin
          if (!guard_q) begin
            err_d = 1'b1;
          end else begin
            ppb_d[i_cmd_sector] = 1'b0;
            cnt_d = TIMER_W'(PROG_CYC);
          end
        end
        CMD_PPB_ERASE: begin
          if (!guard_q) begin
            err_d = 1'b1;
          end else begin
            ppb_d = '1;
            cnt_d = TIMER_W'(ERASE_CYC);
          end
        end
        CMD_PPB_READ: begin
          rdv_d = 1'b1;
          rdd_d = ppb_q[i_cmd_sector] ? DYB_SET_BYTE : DYB_CLEAR_BYTE;
        end
        CMD_DYB_WRITE: begin
          if (i_cmd_data[7:0] == DYB_CLEAR_BYTE) begin
            dyb_d[i_cmd_sector] = 1'b0;
          end else if (i_cmd_data[7:0] == DYB_SET_BYTE) begin
            dyb_d[i_cmd_sector] = 1'b1;
          end
        end
        CMD_DYB_READ: begin
          rdv_d = 1'b1;
          rdd_d = dyb_q[i_cmd_sector] ? DYB_SET_BYTE : DYB_CLEAR_BYTE;
        end
        default: begin
          rdv_d = 1'b0;
        end
      endcase
    end
    busy_d = (cnt_d != '0);
  end

  // nonvolatile state is held in flops; power-on restores the shipped values
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ppb_q    <= '1;
      dyb_q    <= '1;
      pass_q   <= PASSWORD_RESET;
      mode_q   <= MODE_NONE;
      range_q  <= RANGE_NONE;
      cfg_q    <= 4'h0;
      status_write_disable_flag_q   <= 1'b0;
      freeze_q <= 1'b0;
      guard_q  <= 1'b1;
      err_q    <= 1'b0;
      cnt_q    <= '0;
      busy_q   <= 1'b0;
      grant_q  <= 1'b0;
      rdv_q    <= 1'b0;
      rdd_q    <= 8'h00;
    end else begin
      ppb_q    <= ppb_d;
      dyb_q    <= dyb_d;
      pass_q   <= pass_d;
      mode_q   <= mode_d;
      range_q  <= range_d;
      cfg_q    <= cfg_d;
      status_write_disable_flag_q   <= status_write_disable_flag_d;
      freeze_q <= freeze_d;
      guard_q  <= guard_d;
      err_q    <= err_d;
      cnt_q    <= cnt_d;
      busy_q   <= busy_d;
      grant_q  <= grant_d;
      rdv_q    <= rdv_d;
      rdd_q    <= rdd_d;
    end
  end

  assign o_busy                      = busy_q;
  assign o_prog_error                = err_q;
  assign o_guard                     = guard_q;
  assign o_mode                      = mode_q;
  assign o_range_code                = range_q;
  assign o_range_direction_select    = dir_bit;
  assign o_status_write_disable_flag = status_write_disable_flag_q;
  assign o_freeze                    = freeze_q;
  assign o_grant                     = grant_q;
  assign o_rd_valid                  = rdv_q;
  assign o_rd_data                   = rdd_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  logic go;
  assign go = take && !busy_q && !hw_rst;

  a_modify_refused: assert property (go && i_cmd_op == CMD_ARRAY_MODIFY && sect_prot
    |=> err_q && !grant_q) else $error("protected sector modify not refused");
  a_modify_granted: assert property (go && i_cmd_op == CMD_ARRAY_MODIFY && !sect_prot
    |=> grant_q ##1 !grant_q) else $error("unprotected modify not granted once");
  a_guard_hw_reset: assert property (hw_rst |=> guard_q == !pw_mode)
    else $error("guard wrong after hardware reset");
  a_guard_no_set: assert property (!pw_mode && !guard_q && !hw_rst |=> !guard_q)
    else $error("guard set by command in persistent mode");
  a_ppb_locked: assert property (go && !guard_q && i_cmd_op inside {CMD_PPB_PROG, CMD_PPB_ERASE}
    |=> err_q && $stable(ppb_q) && !busy_q) else $error("locked persistent bits changed");
  a_mode_illegal: assert property (go && i_cmd_op == CMD_MODE_PROG
    && i_cmd_data[1:0] == MODE_ILLEGAL |=> err_q && $stable(mode_q))
    else $error("illegal mode accepted");
  a_unlock_delay: assert property (go && pw_mode && i_cmd_op == CMD_PASSWORD_UNLOCK
    && i_cmd_data != pass_q |=> (busy_q && err_q && !guard_q) [*4])
    else $error("failed unlock not delayed");
  a_unlock_match: assert property (go && pw_mode && i_cmd_op == CMD_PASSWORD_UNLOCK
    && i_cmd_data == pass_q |=> guard_q && !busy_q) else $error("matching password not accepted");
  a_freeze_hold: assert property (freeze_q && !hw_rst |=> freeze_q && $stable(range_q))
    else $error("frozen range controls changed");
  a_wp_block: assert property (go && wp_low && status_write_disable_flag_q && i_cmd_op == CMD_WRITE_STATUS
    |=> $stable(range_q) && $stable(cfg_q) && $stable(status_write_disable_flag_q)) else $error("write-protect ignored");
  a_mode_busy: assert property (go && i_cmd_op == CMD_MODE_PROG && !mode_chosen
    && i_cmd_data[1:0] != MODE_ILLEGAL |=> busy_q [*2]) else $error("mode program not busy");

  c_modify_refused: cover property (go && i_cmd_op == CMD_ARRAY_MODIFY && sect_prot);
  c_unlock_ok: cover property (go && pw_mode && i_cmd_op == CMD_PASSWORD_UNLOCK ##1 guard_q);
  c_ppb_erase: cover property (go && guard_q && i_cmd_op == CMD_PPB_ERASE);
  c_frozen: cover property (freeze_q && go && i_cmd_op == CMD_WRITE_STATUS);

endmodule

`default_nettype wire

// *** sim/spi_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module spi_host_model
  import flash_protect_pkg::*;
#(
  parameter int SECT_W = 8
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_busy,
  output var logic               o_cs_n,
  output var logic               o_cmd_valid,
  output var cmd_t               o_cmd_op,
  output var logic [SECT_W-1:0]  o_cmd_sector,
  output var logic [63:0]        o_cmd_data
);
  localparam int FRAME_CYC = 16;

  initial begin
    o_cs_n       = 1'h1;
    o_cmd_valid  = 1'h0;
    o_cmd_op     = CMD_DYB_READ;
    o_cmd_sector = '1;
    o_cmd_data   = '1;
  end

  // a real host polls the progress flag, so a frame never starts while busy
  task automatic send(input cmd_t op, input logic [SECT_W-1:0] sec, input logic [63:0] dat);
    for (int i = 0; i < 500 && i_busy !== 1'h0; i++) @(negedge i_clk_sys);
    @(negedge i_clk_sys);
    o_cs_n       = 1'h0;
    o_cmd_valid  = 1'h1;
    o_cmd_op     = op;
    o_cmd_sector = sec;
    o_cmd_data   = dat;
    repeat (FRAME_CYC) @(negedge i_clk_sys);
    o_cs_n = 1'h1;
    repeat (6) @(negedge i_clk_sys);
    // released fields flip so a stale value can never be mistaken for a command
    o_cmd_valid  = 1'h0;
    o_cmd_op     = cmd_t'(~op);
    o_cmd_sector = ~sec;
    o_cmd_data   = ~dat;
    repeat (2) @(negedge i_clk_sys);
  endtask
endmodule

`default_nettype wire

// *** sim/flash_sector_write_protection_tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module flash_sector_write_protection_tb;
  import flash_protect_pkg::*;
  localparam int TCYC = 16;
  localparam logic [63:0] PASS = 64'h0123456789ABCDEF;
  typedef struct packed {logic d; logic [2:0] c; logic [5:0] s; logic g;} row_t;
  logic        clk_sys, arst_n, hw_reset_n, wp_n, busy, prog_error, guard, dir, status_write_disable_flag;
  logic        freeze, grant, rd_valid, cs_n, cmd_valid;
  logic [1:0]  mode, r;
  logic [2:0]  range_code;
  logic [5:0]  cmd_sector;
  logic [7:0]  rd_data;
  logic [63:0] cmd_data;
  cmd_t        cmd_op;
  int          n_errors = 0, checks = 0, grants = 0, run_len = 0, last_busy = 0;
  int          reads = 0, g_mark = 0;
  row_t rows [26] = '{
    '{1'h0,3'h0,6'h3F,1'h1}, '{1'h0,3'h1,6'h3F,1'h0}, '{1'h0,3'h1,6'h3E,1'h1},
    '{1'h0,3'h2,6'h3E,1'h0}, '{1'h0,3'h2,6'h3D,1'h1}, '{1'h0,3'h3,6'h3C,1'h0},
    '{1'h0,3'h3,6'h3B,1'h1}, '{1'h0,3'h4,6'h38,1'h0}, '{1'h0,3'h4,6'h37,1'h1},
    '{1'h0,3'h5,6'h30,1'h0}, '{1'h0,3'h5,6'h2F,1'h1}, '{1'h0,3'h6,6'h20,1'h0},
    '{1'h0,3'h6,6'h1F,1'h1}, '{1'h0,3'h7,6'h00,1'h0}, '{1'h1,3'h1,6'h00,1'h0},
    '{1'h1,3'h1,6'h01,1'h1}, '{1'h1,3'h2,6'h01,1'h0}, '{1'h1,3'h3,6'h03,1'h0},
    '{1'h1,3'h3,6'h04,1'h1}, '{1'h1,3'h4,6'h07,1'h0}, '{1'h1,3'h4,6'h08,1'h1},
    '{1'h1,3'h5,6'h0F,1'h0}, '{1'h1,3'h5,6'h10,1'h1}, '{1'h1,3'h6,6'h1F,1'h0},
    '{1'h1,3'h6,6'h20,1'h1}, '{1'h1,3'h7,6'h3F,1'h0}};

  flash_sector_write_protection #(
    .NUM_SECTORS(64), .UNLOCK_CYC(TCYC), .PROG_CYC(TCYC), .ERASE_CYC(TCYC)
  ) flash_sector_write_protection_i (
    .i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_hw_reset_n(hw_reset_n), .i_wp_n(wp_n),
    .i_cs_n(cs_n), .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op), .i_cmd_sector(cmd_sector),
    .i_cmd_data(cmd_data), .o_busy(busy), .o_prog_error(prog_error), .o_guard(guard),
    .o_mode(mode), .o_range_code(range_code), .o_range_direction_select(dir),
    .o_status_write_disable_flag(status_write_disable_flag), .o_freeze(freeze), .o_grant(grant),
    .o_rd_valid(rd_valid), .o_rd_data(rd_data));

  spi_host_model #(.SECT_W(6)) spi_host_model_i (
    .i_clk_sys(clk_sys), .i_busy(busy), .o_cs_n(cs_n), .o_cmd_valid(cmd_valid),
    .o_cmd_op(cmd_op), .o_cmd_sector(cmd_sector), .o_cmd_data(cmd_data));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'h0;
    forever #2 clk_sys = ~clk_sys;
  end

  // busy runs, grant and read pulses are counted here: the pulses are gone before a check
  always @(posedge clk_sys) begin
    if (grant === 1'h1) grants <= grants + 1;
    if (rd_valid === 1'h1) reads <= reads + 1;
    if (busy === 1'h1) begin
      run_len <= run_len + 1;
    end else if (run_len != 0) begin
      last_busy <= run_len;
      run_len   <= 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic cmd(input cmd_t op, input logic [5:0] s = 6'h0, input logic [63:0] d = 64'h0);
    spi_host_model_i.send(op, s, d);
  endtask

  task automatic wait_idle;
    for (int i = 0; i < 500 && busy !== 1'h0; i++) @(negedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic pulse_pin(input bit hw);
    if (hw) hw_reset_n = 1'h0;
    else arst_n = 1'h0;
    repeat (8) @(negedge clk_sys);
    hw_reset_n = 1'h1;
    arst_n     = 1'h1;
    repeat (4) @(negedge clk_sys);
  endtask

  task automatic modify(input logic [5:0] s, output logic [1:0] res);
    int g0;
    cmd(CMD_CLEAR_STATUS);
    g0 = grants;
    cmd(CMD_ARRAY_MODIFY, s);
    res = {(grants - g0 == 1) ? 1'h1 : 1'h0, prog_error};
  endtask

  function automatic logic [63:0] stat(input logic [2:0] c, input logic d, input logic w,
                                       input logic f);
    stat = 64'h0;
    stat[RANGE_LSB +: 3]        = c;
    stat[STATUS_WRITE_DISABLE_FLAG_POS]              = w;
    stat[CFG_LSB + DIR_POS]     = d;
    stat[CFG_LSB + FREEZE_POS]  = f;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_errors++;
    give_verdict();
  end

  initial begin
    arst_n     = 1'h0;
    hw_reset_n = 1'h1;
    wp_n       = 1'h1;
    pulse_pin(0);
    chk({busy, prog_error, guard, mode, range_code, dir, status_write_disable_flag, freeze}, 11'h1C0);
    foreach (rows[i]) begin
      cmd(CMD_WRITE_STATUS, 6'h0, stat(rows[i].c, rows[i].d, 1'h0, 1'h0));
      chk({dir, range_code}, {rows[i].d, rows[i].c});
      modify(rows[i].s, r);
      chk(r, {rows[i].g, ~rows[i].g});
    end
    // per-sector locks on top of a range
    cmd(CMD_WRITE_STATUS, 6'h0, stat(3'h1, 1'h0, 1'h0, 1'h0));
    cmd(CMD_DYB_WRITE, 6'h05, {56'h0, DYB_CLEAR_BYTE});
    modify(6'h05, r);
    chk(r, 2'h1);
    cmd(CMD_DYB_WRITE, 6'h05, 64'h5A);
    cmd(CMD_DYB_READ, 6'h05);
    chk(rd_data, 8'h00);
    cmd(CMD_DYB_WRITE, 6'h05, {56'h0, DYB_SET_BYTE});
    modify(6'h05, r);
    chk(r, 2'h2);
    cmd(CMD_WRITE_STATUS, 6'h0, stat(3'h0, 1'h0, 1'h0, 1'h0));
    cmd(CMD_PPB_PROG, 6'h09);
    chk(busy, 1'h1);
    wait_idle();
    chk(last_busy, TCYC);
    modify(6'h09, r);
    chk(r, 2'h1);
    cmd(CMD_PPB_READ, 6'h09);
    chk(rd_data, 8'h00);
    cmd(CMD_PPB_PROG, 6'h0A);
    cmd(CMD_PPB_ERASE);
    wait_idle();
    chk(last_busy, TCYC);
    cmd(CMD_PPB_READ, 6'h0A);
    chk(rd_data, 8'hFF);
    // guard cleared in persistent mode stays cleared until hardware reset
    cmd(CMD_PPB_PROG, 6'h0B);
    cmd(CMD_GUARD_CLEAR);
    cmd(CMD_CLEAR_STATUS);
    cmd(CMD_PPB_ERASE);
    chk({busy, prog_error}, 2'h1);
    cmd(CMD_PPB_READ, 6'h0B);
    chk(rd_data, 8'h00);
    cmd(CMD_PASSWORD_UNLOCK, 6'h0, PASSWORD_RESET);
    chk(guard, 1'h0);
    cmd(CMD_DYB_WRITE, 6'h03, {56'h0, DYB_CLEAR_BYTE});
    pulse_pin(1);
    chk(guard, 1'h1);
    cmd(CMD_DYB_READ, 6'h03);
    chk(rd_data, 8'hFF);
    cmd(CMD_WRITE_STATUS, 6'h0, stat(3'h0, 1'h0, 1'h1, 1'h0));
    wp_n = 1'h0;
    cmd(CMD_WRITE_STATUS, 6'h0, stat(3'h7, 1'h1, 1'h0, 1'h0));
    chk({range_code, dir, status_write_disable_flag}, 5'h1);
    wp_n = 1'h1;
    cmd(CMD_WRITE_STATUS, 6'h0, stat(3'h2, 1'h0, 1'h0, 1'h1));
    chk({range_code, freeze}, 4'h5);
    cmd(CMD_WRITE_STATUS, 6'h0, stat(3'h5, 1'h0, 1'h0, 1'h1));
    cmd(CMD_CLEAR_STATUS);
    cmd(CMD_OTP_AREA_PROG);
    chk(prog_error, 1'h1);
    // hardware reset clears the error flag but must leave the freeze in place
    pulse_pin(1);
    chk({range_code, freeze, prog_error}, 5'hA);
    pulse_pin(0);
    cmd(CMD_MODE_PROG, 6'h0, 64'h0);
    chk({prog_error, mode}, 3'h7);
    cmd(CMD_CLEAR_STATUS);
    cmd(CMD_PASSWORD_PROG, 6'h0, PASS);
    cmd(CMD_MODE_PROG, 6'h0, {62'h0, MODE_PASSWORD});
    wait_idle();
    chk({last_busy[7:0], mode}, {8'(TCYC), MODE_PASSWORD});
    cmd(CMD_MODE_PROG, 6'h0, {62'h0, MODE_PERSIST});
    chk({prog_error, mode}, 3'h5);
    cmd(CMD_CLEAR_STATUS);
    cmd(CMD_WRITE_STATUS, 6'h0, stat(3'h0, 1'h1, 1'h0, 1'h0));
    chk({prog_error, dir}, 2'h2);
    pulse_pin(1);
    chk(guard, 1'h0);
    cmd(CMD_PASSWORD_UNLOCK, 6'h0, PASS ^ 64'h1);
    chk({prog_error, busy, guard}, 3'h6);
    wait_idle();
    chk(last_busy, TCYC);
    cmd(CMD_PASSWORD_UNLOCK, 6'h0, PASS);
    chk({busy, guard}, 2'h1);
    cmd(CMD_GUARD_CLEAR);
    chk(guard, 1'h0);
    chk(reads, 5);
    // fresh device again: configuration program allowed, then persistent mode chosen for good
    pulse_pin(0);
    g_mark = grants;
    cmd(CMD_OTP_CFG_PROG);
    chk(grants - g_mark, 1);
    cmd(CMD_MODE_PROG, 6'h0, {62'h0, MODE_PERSIST});
    cmd(CMD_OTP_CFG_PROG);
    chk({prog_error, mode}, {1'h1, MODE_PERSIST});
    chk(grants - g_mark, 1);
    cmd(CMD_GUARD_CLEAR);
    pulse_pin(1);
    chk(guard, 1'h1);
    give_verdict();
  end
endmodule

`default_nettype wire
